// *** hdl/gpt_pkg.sv ***
package gpt_pkg;
	// ======================================================
	// register byte offsets
	localparam logic [7:0] GLOBAL_CONTROL_REG_OFS = 8'h00;
	localparam logic [7:0] CONTROL_REG_LOW_OFS = 8'h04;
	localparam logic [7:0] CONTROL_REG_HIGH_OFS = 8'h08;
	localparam logic [7:0] SIGNAL_SELECT_REG_OFS = 8'h0C;
	localparam logic [7:0] COUNT_LOW_OFS = 8'h10;
	localparam logic [7:0] COUNT_HIGH_OFS = 8'h14;
	localparam logic [7:0] PERIOD_LOW_OFS = 8'h18;
	localparam logic [7:0] PERIOD_HIGH_OFS = 8'h1C;
	// ======================================================
	// global control fields
	localparam int LOWER_HALF_RUN_BIT = 0;
	localparam int UPPER_HALF_RUN_BIT = 1;
	localparam int COUNTER_CONFIG_LSB = 2;
	// ======================================================
	// control register fields (low and high alike)
	localparam int OUTPUT_STATE_FLAG_BIT = 0;
	localparam int OUTPUT_INVERT_BIT = 1;
	localparam int OUTPUT_STYLE_SELECT_BIT = 2;
	localparam int INPUT_INVERT_BIT = 3;
	localparam int PULSE_WIDTH_LSB = 4;
	localparam int COUNT_ENABLE_MODE_LSB = 6;
	localparam int CLOCK_SOURCE_SELECT_BIT = 8;
	localparam int INPUT_GATE_ENABLE_BIT = 9;
	localparam int PRESCALE_COUNT_LSB = 16;
	localparam int PRESCALE_PERIOD_LSB = 20;
	localparam logic [31:0] CONTROL_WRITE_MASK = 32'h00FF_03FE;
	// ======================================================
	// signal select fields
	localparam int PIN_DIRECTION_SELECT_BIT = 0;
	// ======================================================
	// reset values
	localparam logic [31:0] GLOBAL_CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] SIGNAL_SELECT_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
	// ======================================================
	// encodings
	localparam logic [1:0] CFG_GP64 = 2'h0;
	localparam logic [1:0] CFG_UNCHAINED = 2'h1;
	localparam logic [1:0] CFG_WATCHDOG64 = 2'h2;
	localparam logic [1:0] CFG_CHAINED = 2'h3;
	localparam logic [1:0] ENA_OFF = 2'h0;
	localparam logic [1:0] ENA_ONE_TIME = 2'h1;
	localparam logic [1:0] ENA_CONTINUOUS = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// *** hdl/gpt_out_gen.sv ***
// ======================================================
// pulse / clock output state of one timer half
module gpt_out_gen (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick,
	input wire logic trig,
	input wire logic run,
	input wire logic style,
	input wire logic [1:0] width,
	output logic state_ff
);
	logic [1:0] left_ff;
	logic nxt_state;
	logic [1:0] nxt_left;

	wire pulse_end = state_ff && (left_ff == 2'h0);

	always_comb begin
		nxt_state = state_ff;
		nxt_left = left_ff;
		if (!run) begin
			// run bit low forces the flag back to zero
			nxt_state = 1'b0;
			nxt_left = 2'h0;
		end else if (style) begin
			if (trig) begin
				nxt_state = !state_ff;
			end
		end else if (trig) begin
			// width field 0..3 gives 1..4 timer clocks
			nxt_state = 1'b1;
			nxt_left = width;
		end else if (tick && state_ff) begin
			if (pulse_end) begin
				nxt_state = 1'b0;
			end else begin
				nxt_left = left_ff - 2'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= 1'b0;
			left_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			left_ff <= nxt_left;
		end
	end
endmodule // gpt_out_gen

// *** hdl/gpt_timer_core.sv ***
// The register addresses and register access over AHB-Lite were left to the implementer.
module gpt_timer_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic timer_pin_in,
	output logic timer_pin_out,
	output logic timer_pin_oe,
	output logic period_interrupt,
	output logic period_dma_event
);
	// ======================================================
	// functions
	function automatic logic [31:0] step32(input logic [31:0] c,
		input logic [31:0] p);
		step32 = (c == p) ? 32'h0 : c + 32'h1;
	endfunction

	function automatic logic [63:0] step64(input logic [63:0] c,
		input logic [63:0] p);
		step64 = (c == p) ? 64'h0 : c + 64'h1;
	endfunction

	function automatic logic ena_on(input logic [1:0] m);
		ena_on = (m == gpt_pkg::ENA_ONE_TIME) ||
			(m == gpt_pkg::ENA_CONTINUOUS);
	endfunction

	// ======================================================
	// registers
	logic [31:0] gctl_ff;
	logic [31:0] ctl_lo_ff;
	logic [31:0] ctl_hi_ff;
	logic sel_dir_ff;
	logic [31:0] cnt_lo_ff;
	logic [31:0] cnt_hi_ff;
	logic [31:0] prd_lo_ff;
	logic [31:0] prd_hi_ff;
	logic [3:0] psc_ff;
	logic done_lo_ff;
	logic done_hi_ff;
	logic ptick_lo_ff;
	logic ptick_hi_ff;
	logic sync1_ff;
	logic sync2_ff;
	logic ext_prev_ff;
	logic irq_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] rdata_ff;
	logic state_lo;
	logic state_hi;

	// ======================================================
	// bus decode
	wire addr_phase = hsel && hready && (htrans == gpt_pkg::HTRANS_NONSEQ);
	wire rd_req = addr_phase && !hwrite;
	wire wr_gctl = wr_pend_ff &&
		(wr_addr_ff == gpt_pkg::GLOBAL_CONTROL_REG_OFS);
	wire wr_ctl_lo = wr_pend_ff &&
		(wr_addr_ff == gpt_pkg::CONTROL_REG_LOW_OFS);
	wire wr_ctl_hi = wr_pend_ff &&
		(wr_addr_ff == gpt_pkg::CONTROL_REG_HIGH_OFS);
	wire wr_sel = wr_pend_ff &&
		(wr_addr_ff == gpt_pkg::SIGNAL_SELECT_REG_OFS);
	wire wr_cnt_lo = wr_pend_ff && (wr_addr_ff == gpt_pkg::COUNT_LOW_OFS);
	wire wr_cnt_hi = wr_pend_ff && (wr_addr_ff == gpt_pkg::COUNT_HIGH_OFS);
	wire wr_prd_lo = wr_pend_ff && (wr_addr_ff == gpt_pkg::PERIOD_LOW_OFS);
	wire wr_prd_hi = wr_pend_ff && (wr_addr_ff == gpt_pkg::PERIOD_HIGH_OFS);

	// ======================================================
	// field views
	wire run_lo = gctl_ff[gpt_pkg::LOWER_HALF_RUN_BIT];
	wire run_hi = gctl_ff[gpt_pkg::UPPER_HALF_RUN_BIT];
	wire [1:0] cfg = gctl_ff[gpt_pkg::COUNTER_CONFIG_LSB +: 2];
	wire [1:0] ena_lo = ctl_lo_ff[gpt_pkg::COUNT_ENABLE_MODE_LSB +: 2];
	wire [1:0] ena_hi = ctl_hi_ff[gpt_pkg::COUNT_ENABLE_MODE_LSB +: 2];
	wire [3:0] psc_prd = ctl_lo_ff[gpt_pkg::PRESCALE_PERIOD_LSB +: 4];
	// watchdog encoding runs here as a plain 64-bit timer
	wire is_chained = (cfg == gpt_pkg::CFG_CHAINED);
	wire is_unchained = (cfg == gpt_pkg::CFG_UNCHAINED);
	wire is_64 = (cfg == gpt_pkg::CFG_GP64) ||
		(cfg == gpt_pkg::CFG_WATCHDOG64);

	// ======================================================
	// timer pin and clock source
	// pin is sampled only while it is an input
	wire timer_input_line = sel_dir_ff ? 1'b0 : sync2_ff;
	wire src_ext = ctl_lo_ff[gpt_pkg::CLOCK_SOURCE_SELECT_BIT] &&
		!sel_dir_ff;
	wire src_gate = ctl_lo_ff[gpt_pkg::INPUT_GATE_ENABLE_BIT] &&
		!ctl_lo_ff[gpt_pkg::CLOCK_SOURCE_SELECT_BIT] && !sel_dir_ff;
	wire ext_level = timer_input_line ^
		ctl_lo_ff[gpt_pkg::INPUT_INVERT_BIT];
	wire ext_rise = ext_level && !ext_prev_ff;
	// internal clock is hclk itself: every cycle is a tick
	wire tick_lo = src_ext ? ext_rise :
		(src_gate ? timer_input_line : 1'b1);

	// ======================================================
	// enables
	wire en_lo = (is_unchained ? run_lo : (run_lo && run_hi)) &&
		ena_on(ena_lo) && !done_lo_ff;
	wire en_hi = is_unchained && run_hi && ena_on(ena_hi) &&
		!done_hi_ff;

	// ======================================================
	// counter stepping
	wire [63:0] cnt64 = {cnt_hi_ff, cnt_lo_ff};
	wire [63:0] prd64 = {prd_hi_ff, prd_lo_ff};
	wire [63:0] nxt_cnt64 = step64(cnt64, prd64);
	wire pre_adv = is_chained && en_lo && tick_lo;
	wire lo_adv = is_chained ? (ptick_lo_ff && en_lo) :
		(en_lo && tick_lo);
	wire psc_match = (psc_ff == psc_prd);
	// upper prescaler steps on hclk regardless of the pin
	wire psc_adv = en_hi;
	wire hi_adv = ptick_hi_ff && en_hi;
	wire lo_match = lo_adv && (is_64 ? (cnt64 == prd64) :
		(cnt_lo_ff == prd_lo_ff));
	wire hi_match = hi_adv && (cnt_hi_ff == prd_hi_ff);
	// zero period gives output activity but no interrupt
	wire lo_prd_zero = is_64 ? (prd64 == 64'h0) : (prd_lo_ff == 32'h0);
	wire lo_event = lo_match && !lo_prd_zero;

	logic [31:0] nxt_cnt_lo;
	logic [31:0] nxt_cnt_hi;

	always_comb begin
		nxt_cnt_lo = cnt_lo_ff;
		nxt_cnt_hi = cnt_hi_ff;
		if (is_64) begin
			if (lo_adv) begin
				nxt_cnt_lo = nxt_cnt64[31:0];
				nxt_cnt_hi = nxt_cnt64[63:32];
			end
		end else begin
			if (lo_adv) begin
				nxt_cnt_lo = step32(cnt_lo_ff, prd_lo_ff);
			end
			if (pre_adv) begin
				nxt_cnt_hi = step32(cnt_hi_ff, prd_hi_ff);
			end else if (hi_adv) begin
				nxt_cnt_hi = step32(cnt_hi_ff, prd_hi_ff);
			end
		end
		// software writes take precedence over counting
		if (wr_cnt_lo) begin
			nxt_cnt_lo = hwdata;
		end
		if (wr_cnt_hi) begin
			nxt_cnt_hi = hwdata;
		end
	end

	wire [3:0] nxt_psc = psc_adv ? (psc_match ? 4'h0 : psc_ff + 4'h1) :
		psc_ff;
	wire done_lo_set = lo_match && (ena_lo == gpt_pkg::ENA_ONE_TIME);
	wire done_hi_set = hi_match && (ena_hi == gpt_pkg::ENA_ONE_TIME);
	// a control write or a run-bit clear rearms one-time mode
	// a match in the same cycle as a rearm still wins: the count
	// that just finished must not be lost to a racing write
	wire nxt_done_lo = done_lo_set ? 1'b1 :
		((!run_lo || wr_ctl_lo) ? 1'b0 : done_lo_ff);
	wire nxt_done_hi = done_hi_set ? 1'b1 :
		((!run_hi || wr_ctl_hi) ? 1'b0 : done_hi_ff);

	// ======================================================
	// read mux
	wire [31:0] ctl_lo_view = {ctl_lo_ff[31:1], state_lo};
	wire [31:0] ctl_hi_view = {ctl_hi_ff[31:1], state_hi};
	wire [31:0] ctl_lo_wr = (hwdata & gpt_pkg::CONTROL_WRITE_MASK);
	wire [31:0] rd_mux =
		(haddr == gpt_pkg::GLOBAL_CONTROL_REG_OFS) ? gctl_ff :
		(haddr == gpt_pkg::CONTROL_REG_LOW_OFS) ? ctl_lo_view :
		(haddr == gpt_pkg::CONTROL_REG_HIGH_OFS) ? ctl_hi_view :
		(haddr == gpt_pkg::SIGNAL_SELECT_REG_OFS) ? {31'h0, sel_dir_ff} :
		(haddr == gpt_pkg::COUNT_LOW_OFS) ? cnt_lo_ff :
		(haddr == gpt_pkg::COUNT_HIGH_OFS) ? cnt_hi_ff :
		(haddr == gpt_pkg::PERIOD_LOW_OFS) ? prd_lo_ff :
		(haddr == gpt_pkg::PERIOD_HIGH_OFS) ? prd_hi_ff : 32'h0;

	// ======================================================
	// bus slave state
	// zero wait states: read data is captured at the address edge
	// and stands through the data phase; writes land at its end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h0;
		end else begin
			wr_pend_ff <= addr_phase && hwrite;
			wr_addr_ff <= haddr;
			if (rd_req) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// ======================================================
	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gctl_ff <= gpt_pkg::GLOBAL_CONTROL_RESET;
			ctl_lo_ff <= gpt_pkg::CONTROL_RESET;
			ctl_hi_ff <= gpt_pkg::CONTROL_RESET;
			sel_dir_ff <= gpt_pkg::SIGNAL_SELECT_RESET[0];
			prd_lo_ff <= gpt_pkg::PERIOD_RESET;
			prd_hi_ff <= gpt_pkg::PERIOD_RESET;
		end else begin
			if (wr_gctl) begin
				gctl_ff <= {28'h0, hwdata[3:0]};
			end
			if (wr_ctl_lo) begin
				ctl_lo_ff <= ctl_lo_wr;
			end
			if (wr_ctl_hi) begin
				ctl_hi_ff <= ctl_lo_wr;
			end
			if (wr_sel) begin
				sel_dir_ff <= hwdata[gpt_pkg::PIN_DIRECTION_SELECT_BIT];
			end
			if (wr_prd_lo) begin
				prd_lo_ff <= hwdata;
			end
			if (wr_prd_hi) begin
				prd_hi_ff <= hwdata;
			end
		end
	end

	// ======================================================
	// counting state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_lo_ff <= gpt_pkg::COUNT_RESET;
			cnt_hi_ff <= gpt_pkg::COUNT_RESET;
			psc_ff <= 4'h0;
			done_lo_ff <= 1'b0;
			done_hi_ff <= 1'b0;
			ptick_lo_ff <= 1'b0;
			ptick_hi_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			cnt_lo_ff <= nxt_cnt_lo;
			cnt_hi_ff <= nxt_cnt_hi;
			psc_ff <= nxt_psc;
			done_lo_ff <= nxt_done_lo;
			done_hi_ff <= nxt_done_hi;
			// prescaler output lands one cycle after its match
			ptick_lo_ff <= pre_adv && (cnt_hi_ff == prd_hi_ff);
			ptick_hi_ff <= psc_adv && psc_match;
			irq_ff <= lo_event;
		end
	end

	// ======================================================
	// pin synchroniser, first stage read only by the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
		end else begin
			sync1_ff <= timer_pin_in;
			sync2_ff <= sync1_ff;
			ext_prev_ff <= ext_level;
		end
	end

	// ======================================================
	// output state generators
	// each half keeps its own flag; only the lower one reaches the pin
	gpt_out_gen u_out_lo (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(lo_adv),
		.trig(lo_match),
		.run(run_lo),
		.style(ctl_lo_ff[gpt_pkg::OUTPUT_STYLE_SELECT_BIT]),
		.width(ctl_lo_ff[gpt_pkg::PULSE_WIDTH_LSB +: 2]),
		.state_ff(state_lo)
	);

	gpt_out_gen u_out_hi (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(hi_adv),
		.trig(hi_match),
		.run(run_hi),
		.style(ctl_hi_ff[gpt_pkg::OUTPUT_STYLE_SELECT_BIT]),
		.width(ctl_hi_ff[gpt_pkg::PULSE_WIDTH_LSB +: 2]),
		.state_ff(state_hi)
	);

	// ======================================================
	// outputs
	assign hreadyout = 1'b1;
	assign hresp = gpt_pkg::HRESP_OKAY;
	assign hrdata = rdata_ff;
	// pin floats unless it is an output and the lower half runs
	assign timer_pin_oe = sel_dir_ff && run_lo;
	assign timer_pin_out = timer_pin_oe &&
		(state_lo ^ ctl_lo_ff[gpt_pkg::OUTPUT_INVERT_BIT]);
	assign period_interrupt = irq_ff;
	assign period_dma_event = irq_ff;
endmodule // gpt_timer_core

// *** testbench/gpt_timer_core_monitor.sv ***
module gpt_timer_core_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [1:0] hresp,
	input wire logic [31:0] hrdata,
	input wire logic timer_pin_out,
	input wire logic timer_pin_oe,
	input wire logic period_interrupt,
	input wire logic period_dma_event
);
	timeunit 1ns;
	timeprecision 100ps;
	// ======================================================
	// data phase tracking of writes
	logic wv_ff;
	logic [7:0] wa_ff;
	wire take = hsel && hready && htrans == gpt_pkg::HTRANS_NONSEQ;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv_ff <= 1'b0;
			wa_ff <= 8'h00;
		end else begin
			wv_ff <= take && hwrite;
			wa_ff <= haddr;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_okay: assert property (hreadyout && hresp == gpt_pkg::HRESP_OKAY)
		else $error("bus answer not ready or not okay");
	a_irq_dma_pair: assert property (period_interrupt == period_dma_event)
		else $error("interrupt and dma event differ");
	a_irq_one_cycle: assert property (period_interrupt |=> !period_interrupt)
		else $error("interrupt longer than one cycle");
	a_oe_gates_out: assert property (!timer_pin_oe |-> !timer_pin_out)
		else $error("pin value while not driven");
	a_reset_defaults: assert property ($rose(hresetn) |-> !timer_pin_oe)
		else $error("pin driven after reset");
	a_input_no_drive: assert property (wv_ff && wa_ff == 8'h0C && !hwdata[0]
		|=> !timer_pin_oe)
		else $error("pin driven while input");
	a_run_clear_float: assert property (wv_ff && wa_ff == 8'h00 && !hwdata[0]
		|=> !timer_pin_oe[*2])
		else $error("pin driven after run clear");
	a_unmapped_zero: assert property (take && !hwrite && haddr >= 8'h20
		|=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // gpt_timer_core_monitor

bind gpt_timer_core gpt_timer_core_monitor mon (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
	.period_interrupt(period_interrupt),
	.period_dma_event(period_dma_event));

// *** testbench/gpt_event_sink.sv ***
// ======================================================
// cpu interrupt input and dma event input, counting pulses
module gpt_event_sink (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic irq_in,
	input wire logic dma_in,
	output logic [31:0] irq_count,
	output logic [31:0] dma_count
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_count <= 32'h0;
			dma_count <= 32'h0;
		end else begin
			irq_count <= irq_count + 32'(irq_in === 1'b1);
			dma_count <= dma_count + 32'(dma_in === 1'b1);
		end
	end
endmodule // gpt_event_sink

// *** testbench/gpt_timer_core_tb.sv ***
module gpt_timer_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic ext_on = 0, ext_lvl = 0, gate_hi = 0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, rd, c;
	wire hreadyout, pin_out, pin_oe, irq, dma, pin_in;
	wire [1:0] hresp;
	wire [31:0] hrdata, irq_n, dma_n;
	int err_count = 0, n_tests = 0, ec = 0;
	// the pin is one wire: the timer when it drives, else the outside
	assign pin_in = pin_oe ? pin_out : ext_lvl;
	gpt_timer_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .timer_pin_in(pin_in),
		.timer_pin_out(pin_out), .timer_pin_oe(pin_oe),
		.period_interrupt(irq), .period_dma_event(dma));
	gpt_event_sink sink (.hclk(hclk), .hresetn(hresetn), .irq_in(irq),
		.dma_in(dma), .irq_count(irq_n), .dma_count(dma_n));
	initial forever #12.5 hclk = ~hclk;
	// outside clock: 8 cycles a period, stands at gate_hi while off
	always @(posedge hclk) begin
		ec <= ext_on ? (ec + 1) % 4 : 0;
		ext_lvl <= ext_on ? ext_lvl ^ (ec == 3) : gate_hi;
	end
	task automatic report_and_stop;
		$display("errors %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(string nm, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 50) begin
				err_count++;
				report_and_stop;
			end
			@(posedge hclk);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= gpt_pkg::HTRANS_NONSEQ;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	task automatic setup(logic [31:0] gc, ctl, pl, ph);
		bus(1, gpt_pkg::GLOBAL_CONTROL_REG_OFS, 32'h0);
		bus(1, gpt_pkg::COUNT_LOW_OFS, 32'h0);
		bus(1, gpt_pkg::COUNT_HIGH_OFS, 32'h0);
		bus(1, gpt_pkg::PERIOD_LOW_OFS, pl);
		bus(1, gpt_pkg::PERIOD_HIGH_OFS, ph);
		bus(1, gpt_pkg::CONTROL_REG_LOW_OFS, ctl);
		bus(1, gpt_pkg::GLOBAL_CONTROL_REG_OFS, gc);
		c = irq_n;
	endtask
	// cycles between two interrupts, or two changes of the pin
	task automatic gap(bit pin, int e, string nm);
		logic p;
		int n;
		for (int i = 0; i < 2; i++) begin
			p = pin_out;
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (n < 400 && (pin ? pin_out === p : irq !== 1'b1));
		end
		check(nm, 32'(n), 32'(e));
	endtask
	task automatic idle_check(string nm);
		repeat (40) @(posedge hclk);
		check(nm, irq_n - c, 32'h0);
		bus(0, gpt_pkg::COUNT_LOW_OFS, 32'h0);
		check("count", rd, 32'h0);
	endtask
	// ======================================================
	// scenarios
	task automatic t_reset;
		for (int i = 0; i < 9; i++) begin
			bus(0, 8'(i * 4), 32'h0);
			check("reset reg", rd, 32'h0);
		end
		check("reset oe", 32'(pin_oe), 32'h0);
	endtask
	task automatic t_counting;
		setup(3, 32'h80, 2, 0);
		gap(0, 3, "cont gap");
		check("dma", dma_n, irq_n);
		setup(1, 32'h80, 2, 0);
		idle_check("one run");
		setup(3, 32'h40, 3, 0);
		repeat (40) @(posedge hclk);
		check("one time", irq_n - c, 32'h1);
		setup(3, 32'h80, 0, 0);
		idle_check("zero");
		setup(5, 32'h80, 1, 0);
		gap(0, 2, "unchained");
		setup(32'hF, 32'h80, 1, 1);
		gap(0, 4, "chained");
		// upper half alone: one-time clock style, prescale period 0
		bus(1, gpt_pkg::CONTROL_REG_HIGH_OFS, 32'h44);
		setup(7, 32'h0, 0, 2);
		repeat (20) @(posedge hclk);
		bus(0, gpt_pkg::CONTROL_REG_HIGH_OFS, 32'h0);
		check("high flag", rd, 32'h45);
		bus(1, gpt_pkg::GLOBAL_CONTROL_REG_OFS, 32'h5);
		@(posedge hclk);
		bus(0, gpt_pkg::CONTROL_REG_HIGH_OFS, 32'h0);
		check("high clear", rd, 32'h44);
		setup(32'hB, 32'h80, 2, 0);
		gap(0, 3, "watchdog cfg");
	endtask
	task automatic t_pin;
		bus(1, gpt_pkg::SIGNAL_SELECT_REG_OFS, 32'h1);
		setup(3, 32'h184, 4, 0);
		// let the last write land before looking at the pin
		@(posedge hclk);
		check("oe", 32'(pin_oe), 32'h1);
		gap(1, 5, "toggle");
		bus(1, gpt_pkg::GLOBAL_CONTROL_REG_OFS, 32'h0);
		@(posedge hclk);
		check("float", 32'(pin_oe), 32'h0);
		bus(0, gpt_pkg::CONTROL_REG_LOW_OFS, 32'h0);
		check("flag", 32'(rd[0]), 32'h0);
		t_pulse;
		bus(1, gpt_pkg::SIGNAL_SELECT_REG_OFS, 32'h0);
	endtask
	// inverted pulse of width field 2: idle high, low for 3 clocks
	task automatic t_pulse;
		int n;
		setup(3, 32'hA2, 9, 0);
		repeat (2) @(posedge hclk);
		check("inv idle", 32'(pin_out), 32'h1);
		n = 0;
		while (n < 400 && pin_out !== 1'b0) begin
			@(posedge hclk);
			n++;
		end
		n = 0;
		while (n < 400 && pin_out === 1'b0) begin
			@(posedge hclk);
			n++;
		end
		check("pulse", 32'(n), 32'h3);
	endtask
	task automatic t_ext;
		ext_on <= 1'b1;
		setup(3, 32'h180, 1, 0);
		gap(0, 16, "ext");
		ext_on <= 1'b0;
		// disabled well over one outside period before reuse
		repeat (16) @(posedge hclk);
		setup(3, 32'h280, 1, 0);
		idle_check("gated low");
		// input high for 20 clocks: the count follows it exactly
		setup(3, 32'h280, 32'h100, 0);
		gate_hi <= 1'b1;
		repeat (20) @(posedge hclk);
		gate_hi <= 1'b0;
		repeat (8) @(posedge hclk);
		bus(0, gpt_pkg::COUNT_LOW_OFS, 32'h0);
		check("gated high", rd, 32'h14);
		setup(3, 32'h180, 1, 0);
		idle_check("ext still");
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_counting;
		t_pin;
		t_ext;
		report_and_stop;
	end
endmodule // gpt_timer_core_tb
